// file: design/startup_adaption_regs.vh
// Register map, field layout and timing constants of the startup/adaption config block
`ifndef STARTUP_ADAPTION_REGS_VH
`define STARTUP_ADAPTION_REGS_VH
`define ADDR_STARTUP_CONTROL  16'h4001
`define ADDR_ADAPTION_ENABLES 16'h4002
`define ADDR_ADAPTION_OPTIONS 16'h4003
`define ADDR_AMPLITUDE_TARGET 16'h4004
`define ADDR_AMPLITUDE_LOW    16'h4005
`define ADDR_AMPLITUDE_HIGH   16'h4006
`define WAIT_LSB              0
`define WAIT_MSB              2
`define MODE_LSB              3
`define MODE_MSB              4
`define NOSTART_BIT           5
`define RATE_LSB              0
`define RATE_MSB              2
`define FAULT_HOLD_BIT        3
`define ZCAL_BIT              4
`define STORE_BIT             5
`define RST_STARTUP_CONTROL   8'h00
`define RST_ADAPTION_ENABLES  8'h00
`define RST_ADAPTION_OPTIONS  8'h00
`define RST_AMPLITUDE_TARGET  8'h96
`define RST_AMPLITUDE_LOW     8'h00
`define RST_AMPLITUDE_HIGH    8'hb4
`define RATE_SLOW             3'h0
`define RATE_STEP             3'h6
`define SLOW_COUNT            5'h1f
`define CLK_KHZ               40000
`define MS_PER_MS             1
`define WAIT_MS_0             9'h000
`define WAIT_MS_1             9'h001
`define WAIT_MS_2             9'h003
`define WAIT_MS_3             9'h00a
`define WAIT_MS_4             9'h01e
`define WAIT_MS_5             9'h064
`define WAIT_MS_6             9'h12c
`define RATE_SHIFT_BASE       3'h5
`endif

// file: design/startup_adaption_config.v
// Startup, auto adaption and amplitude monitor configuration registers with their control
`timescale 1ns/10ps
`include "startup_adaption_regs.vh"
module startup_adaption_config #(
  parameter CYC_PER_MS = `CLK_KHZ / `MS_PER_MS,
  parameter NUM_PAR    = 10,
  parameter PAR_W      = 8
) (
  input  wire                     clk_sys,              // System clock, 40 MHz
  input  wire                     reset_n,              // Asynchronous reset, active low
  input  wire [15:0]              reg_addr,             // Register address
  input  wire                     reg_wr,               // Register write strobe
  input  wire [7:0]               reg_wdata,            // Register write data
  input  wire                     reg_rd,               // Register read strobe
  output reg  [7:0]               reg_rdata,            // Register read data
  input  wire                     config_done,          // Configuration complete pulse
  input  wire                     start_cmd,            // Start/restart command pulse
  input  wire                     stop_cmd,             // Stop command pulse
  output reg                      interp_run,           // Interpolation running
  output reg                      startup_wait,         // Startup delay in progress
  output reg  [1:0]               startup_mode,         // Mode latched at start
  input  wire                     calibration_pin_n,    // Calibration pin, active low
  output wire                     cal_sc_active,        // Sin/cos calibration running
  output wire                     cal_z_active,         // Z calibration running
  output reg                      ee_store_req,         // Store corrections pulse
  input  wire                     amp_valid,            // Amplitude refresh pulse
  input  wire [7:0]               measured_amplitude,   // Measured sin/cos amplitude
  output reg                      amplitude_range_flag, // Amplitude out of range
  output wire [7:0]               amplitude_target,     // Gain calibration target
  input  wire                     err_valid,            // Correction request pulse
  input  wire [3:0]               err_sel,              // Correction parameter index
  input  wire                     err_up,               // Request direction, 1 = up
  input  wire [PAR_W-1:0]         err_mag,              // Error magnitude
  output wire [NUM_PAR*PAR_W-1:0] correction_parameter  // Correction parameters
);
  localparam ST_IDLE = 3'b001;
  localparam ST_WAIT = 3'b010;
  localparam ST_RUN  = 3'b100;

  reg        rst_s1_ff;
  reg        rst_n_ff;
  reg  [7:0] startup_control_ff;
  reg  [7:0] adaption_enables_ff;
  reg  [7:0] adaption_options_ff;
  reg  [7:0] amplitude_target_ff;
  reg  [7:0] amplitude_low_limit_ff;
  reg  [7:0] amplitude_high_limit_ff;
  reg  [2:0] state_ff;
  reg  [2:0] nxt_state;
  reg  [8:0] ms_left_ff;
  reg  [31:0] cyc_ff;
  reg        cal_pin_prev_ff;
  reg  [8:0] wait_ms;

  wire [2:0] adaption_rate_sel    = adaption_options_ff[`RATE_MSB:`RATE_LSB];
  wire       adaption_fault_hold  = adaption_options_ff[`FAULT_HOLD_BIT];
  wire       zero_cal_include     = adaption_options_ff[`ZCAL_BIT];
  wire       store_on_cal_release = adaption_options_ff[`STORE_BIT];
  wire       cal_active           = ~calibration_pin_n;
  wire       ms_tick              = (cyc_ff == CYC_PER_MS - 1);
  // Adaption also runs while calibrating; the hold bit pauses it on amplitude fault
  wire       adapt_go = (interp_run | cal_active)
                        & ~(adaption_fault_hold & amplitude_range_flag);

  assign amplitude_target = amplitude_target_ff;
  assign cal_sc_active    = cal_active;
  assign cal_z_active     = cal_active & zero_cal_include;

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1_ff <= 1'b0;
      rst_n_ff  <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_n_ff  <= rst_s1_ff;
    end
  end

  // Register writes and reads
  always @(posedge clk_sys or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      startup_control_ff      <= `RST_STARTUP_CONTROL;
      adaption_enables_ff     <= `RST_ADAPTION_ENABLES;
      adaption_options_ff     <= `RST_ADAPTION_OPTIONS;
      amplitude_target_ff     <= `RST_AMPLITUDE_TARGET;
      amplitude_low_limit_ff  <= `RST_AMPLITUDE_LOW;
      amplitude_high_limit_ff <= `RST_AMPLITUDE_HIGH;
      reg_rdata               <= 8'h00;
    end else begin
      if (reg_wr) begin
        case (reg_addr)
          `ADDR_STARTUP_CONTROL:  startup_control_ff      <= reg_wdata;
          `ADDR_ADAPTION_ENABLES: adaption_enables_ff     <= reg_wdata;
          `ADDR_ADAPTION_OPTIONS: adaption_options_ff     <= reg_wdata;
          `ADDR_AMPLITUDE_TARGET: amplitude_target_ff     <= reg_wdata;
          `ADDR_AMPLITUDE_LOW:    amplitude_low_limit_ff  <= reg_wdata;
          `ADDR_AMPLITUDE_HIGH:   amplitude_high_limit_ff <= reg_wdata;
          default: ;
        endcase
      end
      if (reg_rd) begin
        case (reg_addr)
          `ADDR_STARTUP_CONTROL:  reg_rdata <= startup_control_ff;
          `ADDR_ADAPTION_ENABLES: reg_rdata <= adaption_enables_ff;
          `ADDR_ADAPTION_OPTIONS: reg_rdata <= adaption_options_ff;
          `ADDR_AMPLITUDE_TARGET: reg_rdata <= amplitude_target_ff;
          `ADDR_AMPLITUDE_LOW:    reg_rdata <= amplitude_low_limit_ff;
          `ADDR_AMPLITUDE_HIGH:   reg_rdata <= amplitude_high_limit_ff;
          default:                reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // Reserved code 7 is treated as no delay
  always @* begin
    case (startup_control_ff[`WAIT_MSB:`WAIT_LSB])
      3'h1:    wait_ms = `WAIT_MS_1;
      3'h2:    wait_ms = `WAIT_MS_2;
      3'h3:    wait_ms = `WAIT_MS_3;
      3'h4:    wait_ms = `WAIT_MS_4;
      3'h5:    wait_ms = `WAIT_MS_5;
      3'h6:    wait_ms = `WAIT_MS_6;
      default: wait_ms = `WAIT_MS_0;
    endcase
  end

  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (config_done)
          nxt_state = ST_WAIT;
      end
      ST_WAIT: begin
        if (ms_left_ff == 9'h000)
          nxt_state = startup_control_ff[`NOSTART_BIT] ? ST_IDLE : ST_RUN;
      end
      ST_RUN: begin
        if (stop_cmd)
          nxt_state = ST_IDLE;
      end
      default: nxt_state = ST_IDLE;
    endcase
    if (start_cmd)
      nxt_state = ST_RUN;
  end

  always @(posedge clk_sys or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      state_ff        <= ST_IDLE;
      ms_left_ff      <= 9'h000;
      cyc_ff          <= 32'h0000_0000;
      interp_run      <= 1'b0;
      startup_wait    <= 1'b0;
      startup_mode    <= 2'h0;
      cal_pin_prev_ff <= 1'b1;
      ee_store_req    <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      interp_run   <= (nxt_state == ST_RUN);
      startup_wait <= (nxt_state == ST_WAIT);
      // The ms divider restarts with each wait so the delay is never cut short
      if (state_ff != ST_WAIT || ms_tick)
        cyc_ff <= 32'h0000_0000;
      else
        cyc_ff <= cyc_ff + 32'h0000_0001;
      if (state_ff == ST_IDLE && config_done)
        ms_left_ff <= wait_ms;
      else if (state_ff == ST_WAIT && ms_tick && ms_left_ff != 9'h000)
        ms_left_ff <= ms_left_ff - 9'h001;
      if (nxt_state == ST_RUN && state_ff != ST_RUN)
        startup_mode <= startup_control_ff[`MODE_MSB:`MODE_LSB];
      cal_pin_prev_ff <= calibration_pin_n;
      ee_store_req    <= calibration_pin_n & ~cal_pin_prev_ff & store_on_cal_release;
    end
  end

  always @(posedge clk_sys or negedge rst_n_ff) begin
    if (!rst_n_ff)
      amplitude_range_flag <= 1'b0;
    else if (amp_valid)
      amplitude_range_flag <= (measured_amplitude < amplitude_low_limit_ff)
                            | (measured_amplitude > amplitude_high_limit_ff);
  end

  // One adaption engine per correction parameter
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PAR; gi = gi + 1) begin : g_par
      localparam [2:0] EN_BIT = (gi == 0 || gi == 2) ? 3'd0 : (gi == 1 || gi == 3) ? 3'd3 :
                                (gi == 4) ? 3'd1 : (gi == 5 || gi == 6) ? 3'd4 :
                                (gi == 7) ? 3'd2 : (gi == 8) ? 3'd5 : 3'd6;
      reg [PAR_W-1:0] par_ff;
      reg [4:0]       slow_cnt_ff;
      reg             slow_dir_ff;
      wire [PAR_W-1:0] frac = err_mag >> (`RATE_SHIFT_BASE - adaption_rate_sel);
      wire hit = err_valid && (err_sel == gi) && adapt_go
                 && adaption_enables_ff[EN_BIT];
      assign correction_parameter[gi*PAR_W +: PAR_W] = par_ff;
      always @(posedge clk_sys or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
          par_ff      <= {PAR_W{1'b0}};
          slow_cnt_ff <= 5'h00;
          slow_dir_ff <= 1'b0;
        end else if (hit) begin
          case (adaption_rate_sel)
            `RATE_STEP:
              par_ff <= err_up ? par_ff + 1'b1 : par_ff - 1'b1;
            `RATE_SLOW: begin
              // A direction change restarts the count, which is what buys noise immunity
              slow_dir_ff <= err_up;
              if (slow_dir_ff != err_up)
                slow_cnt_ff <= 5'h01;
              else if (slow_cnt_ff == `SLOW_COUNT) begin
                slow_cnt_ff <= 5'h00;
                par_ff <= err_up ? par_ff + 1'b1 : par_ff - 1'b1;
              end else
                slow_cnt_ff <= slow_cnt_ff + 5'h01;
            end
            3'h1, 3'h2, 3'h3, 3'h4:
              par_ff <= err_up ? par_ff + frac : par_ff - frac;
            default: ;
          endcase
        end
      end
    end
  endgenerate
endmodule // startup_adaption_config

// file: bench/startup_adaption_sva.sv
// Assertion checker for the startup and adaption configuration block
`timescale 1ns/10ps
module startup_adaption_sva (
  input wire        clk_sys,              // Clock
  input wire        reset_n,              // Reset, active low
  input wire        config_done,          // Configuration done
  input wire        start_cmd,            // Start pulse
  input wire        stop_cmd,             // Stop pulse
  input wire        interp_run,           // Running
  input wire        startup_wait,         // Delay running
  input wire        calibration_pin_n,    // Calibration pin
  input wire        cal_sc_active,        // Sin/cos calibration
  input wire        cal_z_active,         // Z calibration
  input wire        ee_store_req,         // Store pulse
  input wire        amp_valid,            // Amplitude refresh
  input wire        amplitude_range_flag, // Out of range
  input wire        err_valid,            // Correction request
  input wire [79:0] correction_parameter  // Corrections
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  sequence s_idle_cfg;
    config_done && !interp_run && !startup_wait && !start_cmd;
  endsequence
  chk_sc_follow: assert property (cal_sc_active == !calibration_pin_n)
    else $error("sin/cos calibration does not follow pin");
  chk_z_needs_pin: assert property (cal_z_active |-> !calibration_pin_n)
    else $error("Z calibration without pin");
  chk_store_single: assert property (ee_store_req |=> !ee_store_req)
    else $error("store request longer than one cycle");
  chk_store_released: assert property (ee_store_req |-> calibration_pin_n)
    else $error("store request while pin held");
  chk_flag_refresh: assert property (!amp_valid |=> $stable(amplitude_range_flag))
    else $error("range flag changed without refresh");
  chk_start_runs: assert property (start_cmd |=> interp_run)
    else $error("start did not run");
  chk_stop_halts: assert property (stop_cmd && !start_cmd |=> !interp_run)
    else $error("stop did not halt");
  chk_wait_begins: assert property (s_idle_cfg |=> startup_wait)
    else $error("startup delay not begun");
  chk_param_quiet: assert property (!err_valid |=> $stable(correction_parameter))
    else $error("correction moved without request");
endmodule // startup_adaption_sva
bind startup_adaption_config startup_adaption_sva i_chk (.clk_sys(clk_sys),
  .reset_n(reset_n), .config_done(config_done), .start_cmd(start_cmd),
  .stop_cmd(stop_cmd), .interp_run(interp_run), .startup_wait(startup_wait),
  .calibration_pin_n(calibration_pin_n), .cal_sc_active(cal_sc_active),
  .cal_z_active(cal_z_active), .ee_store_req(ee_store_req), .amp_valid(amp_valid),
  .amplitude_range_flag(amplitude_range_flag), .err_valid(err_valid),
  .correction_parameter(correction_parameter));

// file: bench/host_model.sv
// Host processor model driving the register port
`timescale 1ns/10ps
module host_model (
  input  wire        clk_sys,   // Clock
  output reg  [15:0] reg_addr,  // Address
  output reg         reg_wr,    // Write strobe
  output reg  [7:0]  reg_wdata, // Write data
  output reg         reg_rd,    // Read strobe
  input  wire [7:0]  reg_rdata  // Read data
);
  initial begin
    reg_addr = 16'h0000;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end
  // Callers send legal wait and rate codes only, but the bench also writes and reads the unmapped address 16'h4007
  task wr(input [15:0] a, input [7:0] d);
    begin
      @(negedge clk_sys);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk_sys);
      reg_wr = 1'b0;
      reg_wdata = ~d;
    end
  endtask
  task rd(input [15:0] a, output [7:0] d);
    begin
      @(negedge clk_sys);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk_sys);
      reg_rd = 1'b0;
      d = reg_rdata;
    end
  endtask
endmodule // host_model

// file: bench/startup_adaption_config_bench.sv
// Self-checking bench for the startup and adaption configuration block
`timescale 1ns/10ps
`include "startup_adaption_regs.vh"
module startup_adaption_config_bench;
  localparam CPM = 4;
  localparam [62:0] MS = {9'd300, 9'd100, 9'd30, 9'd10, 9'd3, 9'd1, 9'd0};
  localparam [55:0] RST = {8'h00, `RST_AMPLITUDE_HIGH, `RST_AMPLITUDE_LOW,
    `RST_AMPLITUDE_TARGET, `RST_ADAPTION_OPTIONS, `RST_ADAPTION_ENABLES, `RST_STARTUP_CONTROL};
  localparam [55:0] PAT = 56'h5ab30a643e052e;
  reg clk_sys = 1'b0, reset_n = 1'b0, config_done = 1'b0, start_cmd = 1'b0, stop_cmd = 1'b0;
  reg calibration_pin_n = 1'b1, amp_valid = 1'b0, err_valid = 1'b0, err_up = 1'b0;
  reg [7:0] measured_amplitude = 8'h00, err_mag = 8'h00;
  reg [3:0] err_sel = 4'h0;
  wire [15:0] reg_addr;
  wire [7:0] reg_wdata, reg_rdata, amplitude_target;
  wire [1:0] startup_mode;
  wire [79:0] corrections;
  wire reg_wr, reg_rd, interp_run, startup_wait, cal_sc_active, cal_z_active, ee_store_req;
  wire amplitude_range_flag;
  integer fails = 0, check_count = 0, i;
  always #12.5 clk_sys = ~clk_sys;
  host_model i_host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  startup_adaption_config #(.CYC_PER_MS(CPM)) i_dut (.clk_sys(clk_sys), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .config_done(config_done), .start_cmd(start_cmd),
    .stop_cmd(stop_cmd), .interp_run(interp_run), .startup_wait(startup_wait),
    .startup_mode(startup_mode), .calibration_pin_n(calibration_pin_n),
    .cal_sc_active(cal_sc_active), .cal_z_active(cal_z_active), .ee_store_req(ee_store_req),
    .amp_valid(amp_valid), .measured_amplitude(measured_amplitude),
    .amplitude_range_flag(amplitude_range_flag), .amplitude_target(amplitude_target),
    .err_valid(err_valid), .err_sel(err_sel), .err_up(err_up), .err_mag(err_mag),
    .correction_parameter(corrections));
  task tick;
    @(negedge clk_sys);
  endtask
  task chk(input [79:0] s, input [79:0] e);
    begin
      check_count = check_count + 1;
      if (s !== e) begin
        fails = fails + 1;
        $display("MISMATCH %0t seen %h expected %h", $time, s, e);
      end
    end
  endtask
  task end_of_test;
    begin
      if (fails == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  // Strobes drop for a cycle between requests so no signal is set twice in one step
  task req(input [3:0] s, input u, input [7:0] m);
    begin
      err_sel = s;
      err_up = u;
      err_mag = m;
      err_valid = 1'b1;
      tick;
      err_valid = 1'b0;
      tick;
    end
  endtask
  task amp(input [7:0] v, input e);
    begin
      measured_amplitude = v;
      amp_valid = 1'b1;
      tick;
      amp_valid = 1'b0;
      tick;
      chk(amplitude_range_flag, e);
    end
  endtask
  task t_regs;
    reg [7:0] d;
    begin
      for (i = 0; i < 7; i = i + 1) begin
        i_host.rd(16'h4001 + i[15:0], d);
        chk(d, RST[8*i+:8]);
        i_host.wr(16'h4001 + i[15:0], PAT[8*i+:8]);
      end
      for (i = 0; i < 7; i = i + 1) begin
        i_host.rd(16'h4001 + i[15:0], d);
        chk(d, i == 6 ? 8'h00 : PAT[8*i+:8]);
      end
      chk(amplitude_target, 8'h64);
    end
  endtask
  task t_start(input integer c);
    integer n, ms;
    reg [1:0] m;
    reg ns;
    begin
      ms = MS[9*c+:9];
      m = c % 3;
      ns = (c == 2);
      i_host.wr(`ADDR_STARTUP_CONTROL, {2'h0, ns, m, c[2:0]});
      stop_cmd = 1'b1;
      tick;
      stop_cmd = 1'b0;
      config_done = 1'b1;
      tick;
      config_done = 1'b0;
      n = 0;
      while (startup_wait && n < 2000) begin
        tick;
        n = n + 1;
      end
      chk(n >= ms * CPM + 1 && n <= ms * (CPM + 1) + 1, 1'b1);
      if (n == 2000) end_of_test;
      chk(interp_run, !ns);
      if (ns) begin
        start_cmd = 1'b1;
        tick;
        start_cmd = 1'b0;
      end
      chk({interp_run, startup_mode}, {1'b1, m});
    end
  endtask
  task t_adapt;
    reg [7:0] b;
    reg [79:0] p;
    integer k;
    begin
      i_host.wr(`ADDR_ADAPTION_ENABLES, 8'h02);
      i_host.wr(`ADDR_ADAPTION_OPTIONS, 8'h06);
      b = corrections[39:32];
      req(4'h4, 1'b1, 8'h00);
      chk(corrections[39:32], b + 8'h01);
      req(4'h4, 1'b0, 8'h00);
      chk(corrections[39:32], b);
      p = corrections;
      req(4'h7, 1'b1, 8'h00);
      chk(corrections, p);
      i_host.wr(`ADDR_ADAPTION_OPTIONS, 8'h03);
      req(4'h4, 1'b1, 8'h10);
      chk(corrections[39:32], b + 8'h04);
      i_host.wr(`ADDR_ADAPTION_OPTIONS, 8'h04);
      req(4'h4, 1'b1, 8'h10);
      chk(corrections[39:32], b + 8'h0c);
      i_host.wr(`ADDR_ADAPTION_OPTIONS, 8'h02);
      req(4'h4, 1'b0, 8'h10);
      chk(corrections[39:32], b + 8'h0a);
      i_host.wr(`ADDR_ADAPTION_OPTIONS, 8'h01);
      req(4'h4, 1'b1, 8'h10);
      chk(corrections[39:32], b + 8'h0b);
      i_host.wr(`ADDR_ADAPTION_OPTIONS, 8'h00);
      req(4'h4, 1'b0, 8'h00);
      b = corrections[39:32];
      for (k = 1; k < 32; k = k + 1) req(4'h4, 1'b1, 8'h00);
      chk(corrections[39:32], b);
      req(4'h4, 1'b1, 8'h00);
      chk(corrections[39:32], b + 8'h01);
      i_host.wr(`ADDR_AMPLITUDE_LOW, 8'd100);
      i_host.wr(`ADDR_AMPLITUDE_HIGH, 8'hb4);
      i_host.wr(`ADDR_ADAPTION_OPTIONS, 8'h0e);
      amp(8'd99, 1'b1);
      amp(8'd100, 1'b0);
      amp(8'd180, 1'b0);
      amp(8'd181, 1'b1);
      p = corrections;
      req(4'h4, 1'b1, 8'h00);
      chk(corrections, p);
      amp(8'd120, 1'b0);
      req(4'h4, 1'b1, 8'h00);
      chk(corrections[39:32], p[39:32] + 8'h01);
    end
  endtask
  task t_cal(input [7:0] o);
    reg s;
    begin
      i_host.wr(`ADDR_ADAPTION_OPTIONS, o);
      calibration_pin_n = 1'b0;
      tick;
      chk({cal_sc_active, cal_z_active}, {1'b1, o[4]});
      calibration_pin_n = 1'b1;
      s = 1'b0;
      repeat (4) begin
        tick;
        s = s | ee_store_req;
      end
      chk(s, o[5]);
    end
  endtask
  initial begin
    repeat (3) tick;
    reset_n = 1'b1;
    repeat (3) tick;
    t_regs;
    for (i = 0; i < 7; i = i + 1) t_start(i);
    t_adapt;
    t_cal(8'h30);
    t_cal(8'h00);
    end_of_test;
  end
endmodule // startup_adaption_config_bench
